// ### rtl/sdram_device.sv
// Two-bank synchronous DRAM: commands, bursts, mode and clock gating
`default_nettype none

// Behaviour
// - Each of two banks holds 524,288 words of 16 bits.
// - Banks are opened and closed independently of each other.
// - All inputs but the reset are taken on the rising edge, the clock gate too.
// - Burst length is one, two, four, eight words or a full page.
// - Burst order is sequential or interleaved, as programmed.
// - Read data follows the read after a latency of two or three cycles.
// - A new column may be given on every cycle of an access.
// - Bursts for reads and writes, or burst reads with single writes.
// - A burst stop or precharge command ends the running burst.
// - Activate takes an eleven-bit row; read and write an eight-bit column.
// - Precharge closes the selected bank, or both with the control bit high.
// - Read or write with the control bit high closes the bank after the burst.
// - Mode set loads the address lines as the operation code.
// - Bank select picks bank 0 or 1 and is the code's top bit.
// - The command is decoded from the row, column and write strobes.
// - Clock gate high makes the next edge valid; low makes it ignored.
// - Gate low gives power-down, clock suspend or self-refresh by prior state.
// - The clock gate is not a command input and is watched on every edge.
// - Commands count only with chip select low; otherwise no command is taken, but a running burst goes on.
// - A high byte mask blocks writing of that data byte.
// - A high byte mask turns that read byte off.
module sdram_device (
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  clock_gate_in,
  input  wire sdram_pkg::cmd_pins_s  pins_in,
  input  wire sdram_pkg::byte_mask_s byte_mask_in,
  input  wire sdram_pkg::word_t      data_lines_in,
  output var  sdram_pkg::word_t      data_lines_out,
  output var  logic [1:0]            data_lines_oe_out,
  output var  sdram_pkg::power_e     power_mode_out,
  output var  logic [1:0]            bank_open_out,
  output var  logic                  burst_busy_out,
  output var  sdram_pkg::opcode_t    mode_operation_code_out
);
  import sdram_pkg::*;

  typedef struct packed {
    logic             busy;
    logic             wr;
    logic             bank;
    logic             auto_pre;
    logic [COL_W-1:0] start;
    logic [COL_W-1:0] beat;
    logic [COL_W-1:0] span;
  } burst_s;

  typedef struct packed {
    logic                        gate;
    power_e                      power;
    opcode_t                     mode;
    logic [BANKS-1:0]            open;
    logic [BANKS-1:0][ROW_W-1:0] row;
    burst_s                      burst;
    logic [1:0]                  pv;
    logic [1:0][DATA_W-1:0]      pd;
    logic [1:0][1:0]             pe;
    word_t                       dout;
    logic [1:0]                  doe;
  } state_s;

  state_s                 s_q;
  state_s                 s_d;
  cmd_e                   cmd;
  store_wr_s              wr;
  word_t                  rd_data;
  burst_s                 eb;
  logic [COL_W-1:0]       col;
  logic [WORD_ADDR_W-1:0] rd_addr;
  logic                   rd_beat;
  logic [1:0]             mask_en;
  logic                   cl3;
  opcode_t                mode_op;

  function automatic logic [COL_W-1:0] span_of(input logic [2:0] code);
    case (code)
      LEN_1:    return 8'h00;
      LEN_2:    return 8'h01;
      LEN_4:    return 8'h03;
      LEN_8:    return 8'h07;
      LEN_PAGE: return 8'hff;
      default:  return 8'h00;
    endcase
  endfunction

  // Wraps inside the aligned block of the burst length
  function automatic logic [COL_W-1:0] beat_col(input burst_s bt,
                                                input logic interleave);
    logic [COL_W-1:0] off;
    off = interleave ? (bt.start ^ bt.beat) : COL_W'(bt.start + bt.beat);
    return (bt.start & ~bt.span) | (off & bt.span);
  endfunction

  sdram_cmd_decode u_decode (
    .pins_in (pins_in),
    .cmd_out (cmd)
  );

  sdram_bank_store u_store (
    .clock_in    (clock_in),
    .wr_in       (wr),
    .rd_bank_in  (eb.bank),
    .rd_addr_in  (rd_addr),
    .rd_data_out (rd_data)
  );

  assign cl3     = (s_q.mode[MODE_CL_LSB +: 3] == CL_3);
  assign mode_op = {pins_in.bank_select_bit, pins_in.row_address_lines};
  assign mask_en = ~{byte_mask_in.high_byte_mask, byte_mask_in.low_byte_mask};

  // Burst seen at this edge; a new column command replaces the old one
  always_comb begin
    eb = s_q.burst;
    if (s_q.gate) begin
      case (cmd)
        CMD_READ, CMD_WRITE: begin
          // Column to a closed bank is dropped
          if (s_q.open[pins_in.bank_select_bit]) begin
            eb.busy     = 1'b1;
            eb.wr       = (cmd == CMD_WRITE);
            eb.bank     = pins_in.bank_select_bit;
            eb.auto_pre = pins_in.row_address_lines[PRE_ALL_BIT];
            eb.start    = pins_in.row_address_lines[COL_W-1:0];
            eb.beat     = '0;
            eb.span     = span_of(s_q.mode[MODE_LEN_LSB +: 3]);
            if (eb.wr && s_q.mode[MODE_WRITE_SINGLE_BIT]) begin
              eb.span = '0;
            end
          end
        end
        CMD_BURST_STOP, CMD_PRECHARGE: eb.busy = 1'b0;
        default: ;
      endcase
    end
    col     = beat_col(eb, s_q.mode[MODE_ORDER_BIT]);
    rd_addr = {s_q.row[eb.bank], col};
    rd_beat = s_q.gate && eb.busy && !eb.wr;
  end

  always_comb begin
    s_d      = s_q;
    wr       = '0;
    // Taken on every edge, ignored ones too, so the gate can wake us
    s_d.gate = clock_gate_in;
    if (clock_gate_in) begin
      s_d.power = PWR_RUN;
    end else if (s_q.power == PWR_RUN) begin
      if (s_q.gate && cmd == CMD_REFRESH) begin
        s_d.power = PWR_SELF_REFRESH;
      end else if (s_q.burst.busy || (|s_q.pv)) begin
        s_d.power = PWR_SUSPEND;
      end else begin
        s_d.power = PWR_DOWN;
      end
    end
    // An ignored edge freezes banks, burst and read pipe alike
    if (s_q.gate) begin
      case (cmd)
        CMD_ACTIVATE: begin
          s_d.open[pins_in.bank_select_bit] = 1'b1;
          s_d.row[pins_in.bank_select_bit]  = pins_in.row_address_lines;
        end
        CMD_PRECHARGE: begin
          if (pins_in.row_address_lines[PRE_ALL_BIT]) begin
            s_d.open = '0;
          end else begin
            s_d.open[pins_in.bank_select_bit] = 1'b0;
          end
        end
        CMD_MODE_SET: s_d.mode = mode_op;
        // Deselect, no-op and refresh leave the banks as they are
        default: ;
      endcase
      s_d.burst = eb;
      if (eb.busy) begin
        s_d.burst.beat = COL_W'(eb.beat + 8'h01);
        if (eb.beat == eb.span) begin
          s_d.burst.busy = 1'b0;
          // A same-edge activate of that bank outranks the late close
          if (eb.auto_pre && !(cmd == CMD_ACTIVATE
                               && pins_in.bank_select_bit == eb.bank)) begin
            s_d.open[eb.bank] = 1'b0;
          end
        end
        if (eb.wr) begin
          wr.en      = 1'b1;
          wr.bank    = eb.bank;
          wr.addr    = rd_addr;
          wr.data    = data_lines_in;
          wr.byte_en = mask_en;
        end
      end
      // Mask is taken with the beat and delayed in step with the data
      s_d.pv   = {s_q.pv[0], rd_beat};
      s_d.pd   = {s_q.pd[0], rd_data};
      s_d.pe   = {s_q.pe[0], mask_en};
      s_d.dout = s_q.pd[cl3];
      s_d.doe  = s_q.pv[cl3] ? s_q.pe[cl3] : 2'h0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q      <= '0;
      s_q.gate <= 1'b1;
      s_q.mode <= MODE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_lines_out          = s_q.dout;
  assign data_lines_oe_out       = s_q.doe;
  assign power_mode_out          = s_q.power;
  assign bank_open_out           = s_q.open;
  assign burst_busy_out          = s_q.burst.busy;
  assign mode_operation_code_out = s_q.mode;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  edge_ignored_a : assert property (
    !s_q.gate |=> s_q.open == $past(s_q.open) && s_q.mode == $past(s_q.mode)
                  && s_q.burst == $past(s_q.burst))
    else $error("Ignored edge changed device state");

  deselect_hold_a : assert property (
    s_q.gate && cmd == CMD_DESELECT && !s_q.burst.busy
    |=> s_q.open == $past(s_q.open) && s_q.row == $past(s_q.row))
    else $error("Deselected edge changed bank state");

  activate_row_a : assert property (
    s_q.gate && cmd == CMD_ACTIVATE
    |=> s_q.open[$past(pins_in.bank_select_bit)]
        && s_q.row[$past(pins_in.bank_select_bit)]
           == $past(pins_in.row_address_lines))
    else $error("Activate did not open the row");

  precharge_all_a : assert property (
    s_q.gate && cmd == CMD_PRECHARGE && pins_in.row_address_lines[PRE_ALL_BIT]
    |=> s_q.open == 2'h0)
    else $error("Precharge all left a bank open");

  precharge_one_a : assert property (
    s_q.gate && cmd == CMD_PRECHARGE
    && !pins_in.row_address_lines[PRE_ALL_BIT]
    |=> !s_q.open[$past(pins_in.bank_select_bit)]
        && s_q.open[!$past(pins_in.bank_select_bit)]
           == $past(s_q.open[!pins_in.bank_select_bit]))
    else $error("Single precharge hit the wrong bank");

  mode_load_a : assert property (
    s_q.gate && cmd == CMD_MODE_SET |=> s_q.mode == $past(mode_op))
    else $error("Mode set did not load the operation code");

  burst_stop_a : assert property (
    s_q.gate && (cmd == CMD_BURST_STOP || cmd == CMD_PRECHARGE)
    |=> !s_q.burst.busy)
    else $error("Burst still running after stop");

  single_write_a : assert property (
    s_q.gate && cmd == CMD_WRITE && s_q.open[pins_in.bank_select_bit]
    && s_q.mode[MODE_WRITE_SINGLE_BIT] |=> !s_q.burst.busy)
    else $error("Single write mode ran a write burst");

  auto_close_a : assert property (
    s_q.gate && s_q.burst.busy && s_q.burst.auto_pre
    && s_q.burst.beat == s_q.burst.span && cmd == CMD_NOP
    |=> !s_q.open[$past(s_q.burst.bank)])
    else $error("Auto precharge did not close the bank");

  read_lat2_a : assert property (
    rd_beat && !cl3 && clock_gate_in
    |-> ##2 data_lines_oe_out == $past(mask_en, 2))
    else $error("Latency two read byte enables wrong");

  read_lat3_a : assert property (
    rd_beat && cl3 && clock_gate_in ##1 clock_gate_in
    |-> ##2 data_lines_oe_out == $past(mask_en, 3))
    else $error("Latency three read byte enables wrong");

  self_refresh_a : assert property (
    s_q.gate && cmd == CMD_REFRESH && !clock_gate_in && s_q.power == PWR_RUN
    |=> s_q.power == PWR_SELF_REFRESH)
    else $error("Refresh with gate low did not self-refresh");

  suspend_entry_a : assert property (
    !clock_gate_in && s_q.power == PWR_RUN && s_q.burst.busy
    && !(s_q.gate && cmd == CMD_REFRESH) |=> s_q.power == PWR_SUSPEND)
    else $error("Gate low in a burst did not suspend");

  gate_wake_a : assert property (
    clock_gate_in |=> s_q.power == PWR_RUN)
    else $error("Gate high did not return to run");

endmodule

`default_nettype wire

// ### rtl/sdram_pkg.sv
// Shared types and constants of the two-bank synchronous DRAM model
`default_nettype none

package sdram_pkg;

  localparam int BANKS          = 2;
  localparam int WORDS_PER_BANK = 524288;
  localparam int ROW_W          = 11;
  localparam int COL_W          = 8;
  localparam int DATA_W         = 16;
  localparam int OPCODE_W       = ROW_W + 1;
  localparam int WORD_ADDR_W    = ROW_W + COL_W;

  // Operation code fields, then the address bit for precharge all and auto precharge
  localparam int MODE_LEN_LSB          = 0;
  localparam int MODE_ORDER_BIT        = 3;
  localparam int MODE_CL_LSB           = 4;
  localparam int MODE_WRITE_SINGLE_BIT = 9;
  localparam int PRE_ALL_BIT           = 10;

  localparam logic [2:0] LEN_1    = 3'h0;
  localparam logic [2:0] LEN_2    = 3'h1;
  localparam logic [2:0] LEN_4    = 3'h2;
  localparam logic [2:0] LEN_8    = 3'h3;
  localparam logic [2:0] LEN_PAGE = 3'h7;
  localparam logic [2:0] CL_3     = 3'h3;

  // Burst of one, sequential, latency two, burst writes
  localparam logic [OPCODE_W-1:0] MODE_RESET = 12'h020;

  // Strobe patterns, row/column/write order, active low
  localparam logic [2:0] STROBES_NOP      = 3'h7;
  localparam logic [2:0] STROBES_ACTIVATE = 3'h3;
  localparam logic [2:0] STROBES_READ     = 3'h5;
  localparam logic [2:0] STROBES_WRITE    = 3'h4;
  localparam logic [2:0] STROBES_PRECHG   = 3'h2;
  localparam logic [2:0] STROBES_REFRESH  = 3'h1;
  localparam logic [2:0] STROBES_MODE_SET = 3'h0;
  localparam logic [2:0] STROBES_STOP     = 3'h6;

  typedef logic [DATA_W-1:0]   word_t;
  typedef logic [OPCODE_W-1:0] opcode_t;

  typedef enum logic [3:0] {
    CMD_DESELECT,
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_REFRESH,
    CMD_MODE_SET,
    CMD_BURST_STOP
  } cmd_e;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DOWN,
    PWR_SUSPEND,
    PWR_SELF_REFRESH
  } power_e;

  typedef struct packed {
    logic             chip_select_n;
    logic             row_strobe_n;
    logic             column_strobe_n;
    logic             write_strobe_n;
    logic             bank_select_bit;
    logic [ROW_W-1:0] row_address_lines;
  } cmd_pins_s;

  typedef struct packed {
    logic high_byte_mask;
    logic low_byte_mask;
  } byte_mask_s;

  typedef struct packed {
    logic                   en;
    logic                   bank;
    logic [WORD_ADDR_W-1:0] addr;
    word_t                  data;
    logic [1:0]             byte_en;
  } store_wr_s;

endpackage

`default_nettype wire

// ### rtl/sdram_cmd_decode.sv
// Command decoder from chip select and the three strobes
`default_nettype none

module sdram_cmd_decode (
  input  wire sdram_pkg::cmd_pins_s pins_in,
  output var  sdram_pkg::cmd_e      cmd_out
);
  import sdram_pkg::*;

  logic [2:0] strobes;

  assign strobes = {pins_in.row_strobe_n, pins_in.column_strobe_n,
                    pins_in.write_strobe_n};

  always_comb begin
    if (pins_in.chip_select_n) begin
      cmd_out = CMD_DESELECT;
    end else begin
      case (strobes)
        STROBES_ACTIVATE: cmd_out = CMD_ACTIVATE;
        STROBES_READ:     cmd_out = CMD_READ;
        STROBES_WRITE:    cmd_out = CMD_WRITE;
        STROBES_PRECHG:   cmd_out = CMD_PRECHARGE;
        STROBES_REFRESH:  cmd_out = CMD_REFRESH;
        STROBES_MODE_SET: cmd_out = CMD_MODE_SET;
        STROBES_STOP:     cmd_out = CMD_BURST_STOP;
        default:          cmd_out = CMD_NOP;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### rtl/sdram_bank_store.sv
// Cell array of both banks with byte-masked writes
`default_nettype none

module sdram_bank_store (
  input  wire logic                              clock_in,
  input  wire sdram_pkg::store_wr_s              wr_in,
  input  wire logic                              rd_bank_in,
  input  wire logic [sdram_pkg::WORD_ADDR_W-1:0] rd_addr_in,
  output var  sdram_pkg::word_t                  rd_data_out
);
  import sdram_pkg::*;

  word_t bank_word [BANKS];

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      // Row in the upper bits, column in the lower
      word_t cells [WORDS_PER_BANK];

      always_ff @(posedge clock_in) begin
        if (wr_in.en && wr_in.bank == 1'(b)) begin
          for (int i = 0; i < 2; i++) begin
            if (wr_in.byte_en[i]) begin
              cells[wr_in.addr][8*i +: 8] <= wr_in.data[8*i +: 8];
            end
          end
        end
      end

      // Unregistered read; the read pipe in the top supplies the latency
      assign bank_word[b] = cells[rd_addr_in];
    end
  endgenerate

  assign rd_data_out = bank_word[rd_bank_in];

endmodule

`default_nettype wire

// ### verif/sdram_host_model.sv
// Controller model driving the device's command, mask and data pins
`default_nettype none

module sdram_host_model (
  input  wire logic                  clock_in,
  output var  sdram_pkg::cmd_pins_s  pins_out,
  output var  sdram_pkg::byte_mask_s mask_out,
  output var  sdram_pkg::word_t      data_out,
  output var  logic                  gate_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_pkg::*;

  // One refresh per slot gives 4096 per 64 ms; bench runs are far shorter
  localparam int REFRESH_GAP = 3906;

  initial begin
    pins_out = {1'b0, STROBES_NOP, 1'b0, 11'h0};
    mask_out = 2'h0;
    data_out = 16'h0;
    gate_out = 1'b1;
  end

  // Drives at the falling edge so the rising edge sees settled levels
  task automatic issue(input logic       cs_n,
                       input logic [2:0]  s,
                       input logic        b,
                       input logic [10:0] a,
                       input logic [1:0]  m,
                       input word_t       d);
    @(negedge clock_in);
    // Unselected lines mean nothing: show the inverse, not a stale value
    if (cs_n) begin
      pins_out = {cs_n, s, ~pins_out.bank_select_bit,
                  ~pins_out.row_address_lines};
    end else begin
      pins_out = {cs_n, s, b, a};
    end
    mask_out = m;
    data_out = d;
  endtask

  // Breaking the keep-high habit is only done when the bench asks
  task automatic gate(input logic g, input logic [2:0] s);
    issue(1'b0, s, 1'b0, 11'h0, 2'h0, 16'h0);
    gate_out = g;
  endtask
endmodule

`default_nettype wire

// ### verif/test_sdram_device.sv
// Self-checking bench of the two-bank synchronous DRAM device
`default_nettype none

module test_sdram_device;
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_pkg::*;

  typedef struct {
    logic       b;
    logic [7:0] col;
    word_t      d;
    logic [1:0] m;
    word_t      e;
  } row_s;

  logic       clock_in;
  logic       rst_n_in;
  logic       gate;
  cmd_pins_s  pins;
  byte_mask_s mask;
  word_t      din;
  word_t      dout;
  logic [1:0] oe;
  logic [1:0] bank_open;
  power_e     pwr;
  logic       busy;
  opcode_t    mode;
  word_t      exp;
  int         errors;
  int         compares;
  row_s       rows [4] = '{
    '{1'b0, 8'h10, 16'h1234, 2'b00, 16'h1234},
    '{1'b1, 8'h10, 16'habcd, 2'b01, 16'hab5a},
    '{1'b0, 8'hff, 16'hc3c3, 2'b10, 16'h5ac3},
    '{1'b1, 8'h00, 16'h0ff0, 2'b11, 16'h5a5a}};

  sdram_host_model host (
    .clock_in(clock_in),
    .pins_out(pins),
    .mask_out(mask),
    .data_out(din),
    .gate_out(gate)
  );

  sdram_device uut (
    .clock_in               (clock_in),
    .rst_n_in               (rst_n_in),
    .clock_gate_in          (gate),
    .pins_in                (pins),
    .byte_mask_in           (mask),
    .data_lines_in          (din),
    .data_lines_out         (dout),
    .data_lines_oe_out      (oe),
    .power_mode_out         (pwr),
    .bank_open_out          (bank_open),
    .burst_busy_out         (busy),
    .mode_operation_code_out(mode)
  );

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic close_out();
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic cmd(input logic [2:0] s, input logic b = 1'b0,
                     input logic [10:0] a = 11'h0,
                     input logic [1:0] m = 2'h0, input word_t d = 16'h0);
    host.issue(1'b0, s, b, a, m, d);
  endtask

  task automatic nop(input int n);
    repeat (n) cmd(STROBES_NOP);
  endtask

  // Latency two: the word is settled two falling edges after the read
  task automatic rd(input logic b, input logic [7:0] c,
                    input logic [1:0] m, input word_t e);
    word_t k;
    k = {{8{~m[1]}}, {8{~m[0]}}};
    cmd(STROBES_READ, b, {3'h0, c}, m);
    nop(2);
    chk(dout & k, e & k);
    chk({14'h0, oe}, {14'h0, ~m});
  endtask

  initial begin
    #5000;
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    compares = 0;
    rst_n_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rst_n_in = 1'b1;
    chk({4'h0, mode}, {4'h0, MODE_RESET});
    chk({9'h0, oe, bank_open, busy, pwr}, {14'h0, PWR_RUN});
    cmd(STROBES_ACTIVATE, 1'b0, 11'h7ff);
    cmd(STROBES_ACTIVATE, 1'b1, 11'h001);
    nop(1);
    chk({14'h0, bank_open}, 16'h3);
    foreach (rows[i]) begin
      cmd(STROBES_WRITE, rows[i].b, {3'h0, rows[i].col}, 2'h0, 16'h5a5a);
      cmd(STROBES_WRITE, rows[i].b, {3'h0, rows[i].col}, rows[i].m,
          rows[i].d);
      rd(rows[i].b, rows[i].col, 2'h0, rows[i].e);
    end
    rd(1'b0, 8'h10, 2'b10, 16'h1234);
    cmd(STROBES_READ, 1'b0, 11'h010);
    cmd(STROBES_READ, 1'b1, 11'h010);
    nop(1);
    chk(dout, 16'h1234);
    nop(1);
    chk(dout, 16'hab5a);
    for (int i = 0; i < 4; i++) begin
      cmd(STROBES_WRITE, 1'b0, 11'(8 + i), 2'h0, 16'(16'h1000 + i));
    end
    // Sequential, then interleaved order of a four-word burst from column 9
    for (int il = 0; il < 2; il++) begin
      cmd(STROBES_MODE_SET, 1'b0, il ? 11'h02a : 11'h022);
      cmd(STROBES_READ, 1'b0, 11'h009);
      chk({4'h0, mode}, il ? 16'h02a : 16'h022);
      nop(1);
      chk({15'h0, busy}, 16'h1);
      for (int k = 0; k < 4; k++) begin
        nop(1);
        exp = 16'(16'h1000 + (il ? (1 ^ k) : ((1 + k) & 3)));
        chk(dout, exp);
      end
      nop(1);
      chk({14'h0, oe}, 16'h0);
    end
    cmd(STROBES_READ, 1'b0, 11'h008);
    cmd(STROBES_STOP);
    nop(1);
    chk({15'h0, busy}, 16'h0);
    nop(3);
    cmd(STROBES_MODE_SET, 1'b0, 11'h030);
    cmd(STROBES_READ, 1'b0, 11'h008);
    nop(2);
    chk({14'h0, oe}, 16'h0);
    nop(1);
    chk(dout, 16'h1000);
    cmd(STROBES_MODE_SET, 1'b0, 11'h222);
    cmd(STROBES_WRITE, 1'b0, 11'h008, 2'h0, 16'hbeef);
    nop(4);
    cmd(STROBES_MODE_SET, 1'b0, 11'h020);
    rd(1'b0, 8'h09, 2'h0, 16'h1001);
    rd(1'b0, 8'h08, 2'h0, 16'hbeef);
    // Eight-word burst ends on its eighth beat; a page burst runs on
    for (int ln = 0; ln < 2; ln++) begin
      cmd(STROBES_MODE_SET, 1'b0, ln ? 11'h027 : 11'h023);
      cmd(STROBES_READ, 1'b0, 11'h008);
      nop(7);
      chk({15'h0, busy}, 16'h1);
      nop(1);
      chk({15'h0, busy}, {15'h0, ln[0]});
      cmd(STROBES_STOP);
    end
    // Gate low mid-burst suspends it; the frozen edges add no beats
    cmd(STROBES_MODE_SET, 1'b0, 11'h022);
    cmd(STROBES_READ, 1'b0, 11'h008);
    host.gate(1'b0, STROBES_NOP);
    nop(1);
    chk({13'h0, busy, pwr}, {13'h0, 1'b1, PWR_SUSPEND});
    host.gate(1'b1, STROBES_NOP);
    nop(2);
    chk({15'h0, busy}, 16'h1);
    nop(2);
    chk({15'h0, busy}, 16'h0);
    cmd(STROBES_MODE_SET, 1'b0, 11'h021);
    cmd(STROBES_PRECHG, 1'b0, 11'h000);
    nop(1);
    chk({14'h0, bank_open}, 16'h2);
    cmd(STROBES_ACTIVATE, 1'b0, 11'h0);
    cmd(STROBES_READ, 1'b1, 11'h400);
    nop(1);
    chk({14'h0, bank_open}, 16'h3);
    nop(2);
    chk({14'h0, bank_open}, 16'h1);
    cmd(STROBES_PRECHG, 1'b0, 11'h400);
    nop(1);
    chk({14'h0, bank_open}, 16'h0);
    host.issue(1'b1, STROBES_ACTIVATE, 1'b1, 11'h0, 2'h0, 16'h0);
    nop(1);
    chk({14'h0, bank_open}, 16'h0);
    host.gate(1'b0, STROBES_NOP);
    cmd(STROBES_ACTIVATE, 1'b1);
    nop(1);
    chk({14'h0, pwr}, {14'h0, PWR_DOWN});
    host.gate(1'b1, STROBES_NOP);
    nop(2);
    chk({12'h0, bank_open, pwr}, {14'h0, PWR_RUN});
    host.gate(1'b0, STROBES_REFRESH);
    nop(2);
    chk({14'h0, pwr}, {14'h0, PWR_SELF_REFRESH});
    host.gate(1'b1, STROBES_NOP);
    nop(2);
    cmd(STROBES_MODE_SET, 1'b0, 11'h032);
    nop(1);
    rst_n_in = 1'b0;
    @(negedge clock_in);
    chk({4'h0, mode}, {4'h0, MODE_RESET});
    rst_n_in = 1'b1;
    cmd(STROBES_ACTIVATE, 1'b1);
    nop(1);
    chk({14'h0, bank_open}, 16'h2);
    close_out();
  end
endmodule

`default_nettype wire
